// ### rtl/pmsp_pkg.sv
// constants and types shared by the phy management and status port
package pmsp_pkg;
	// -----------------------------------------------------------------
	// management port geometry
	// -----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [31:0] RST_VAL = 32'h0;

	// -----------------------------------------------------------------
	// register word addresses
	// -----------------------------------------------------------------
	localparam logic [7:0] OFS_AN_RF = 8'hC2;
	localparam logic [7:0] OFS_CTRL = 8'hD0;
	localparam logic [7:0] OFS_STAT = 8'hD1;
	localparam logic [7:0] OFS_IRQ = 8'hD2;
	localparam logic [7:0] OFS_MASK = 8'hD3;
	localparam logic [7:0] OFS_RXLAT = 8'hD4;
	localparam logic [7:0] OFS_TXLAT = 8'hD5;

	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int RF_BIT = 13;
	localparam int CTL_TS_EN = 0;
	localparam int CTL_10G = 1;
	localparam int CTL_PERMIT = 2;
	localparam int CTL_PAUSE = 3;
	localparam int CTL_TRIG_LSB = 4;
	localparam int CTL_W = 8;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_RLV = 1;
	localparam int IRQ_SLIP = 2;
	localparam int IRQ_PERMIT = 3;
	localparam int IRQ_W = 4;
	localparam int TRIG_W = 4;

	// -----------------------------------------------------------------
	// latency word formats (fraction in the low ten bits)
	// -----------------------------------------------------------------
	localparam int LAT_GIG_W = 22;
	localparam int LAT_TEN_W = 16;
	localparam int LAT_FRAC_W = 10;
	localparam logic [15:0] LAT_TEN_MAX = 16'hFFFF;

	typedef enum logic [0:0] {st_idle, st_hold} pmsp_slip_st_type;
endpackage : pmsp_pkg

// ### rtl/pmsp_slip.sv
// bit-slip sequencer: one deserializer slip per request
`timescale 1ns/100ps
`default_nettype none
module pmsp_slip
(
	input wire logic clk,
	input wire logic rst_b,
	pmsp_slip_if.seq sl
);
	pmsp_pkg::pmsp_slip_st_type st_r;
	logic drop_r;
	logic pause_r;
	logic done_r;
	logic fire;

	// a new request is taken only from idle
	assign fire = (st_r == pmsp_pkg::st_idle) && sl.req;

	// -----------------------------------------------------------------
	// state and pulses
	// -----------------------------------------------------------------
	// hold until the request drops so one level gives one slip
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			st_r <= pmsp_pkg::st_idle;
		else
			unique case (st_r)
				pmsp_pkg::st_idle:
					if (sl.req)
						st_r <= pmsp_pkg::st_hold;
				pmsp_pkg::st_hold:
					if (!sl.req)
						st_r <= pmsp_pkg::st_idle;
			endcase
	end

	// drop one bit or pause one serial cycle, never both
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			drop_r <= 1'b0;
			pause_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			drop_r <= fire && !sl.pause_mode;
			pause_r <= fire && sl.pause_mode;
			done_r <= fire;
		end
	end

	assign sl.drop_bit = drop_r;
	assign sl.pause_clk = pause_r;
	assign sl.done = done_r;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	property p_slip_once;
		(drop_r || pause_r) |=> !(drop_r || pause_r);
	endproperty
	a_slip_once: assert property (p_slip_once)
		else $error("slip pulse longer than one cycle");

	property p_slip_kind;
		fire |=> (drop_r != pause_r) && (pause_r == $past(sl.pause_mode));
	endproperty
	a_slip_kind: assert property (p_slip_kind)
		else $error("slip request gave wrong or no pulse");

	c_slip_pause: cover property (fire && sl.pause_mode);
endmodule : pmsp_slip
`default_nettype wire

// ### rtl/pmsp_slip_if.sv
// bundle between the register core and the bit-slip sequencer
`timescale 1ns/100ps
`default_nettype none
interface pmsp_slip_if;
	logic req;
	logic pause_mode;
	logic drop_bit;
	logic pause_clk;
	logic done;
	modport ctl (output req, pause_mode, input drop_bit, pause_clk, done);
	modport seq (input req, pause_mode, output drop_bit, pause_clk, done);
endinterface : pmsp_slip_if
`default_nettype wire

// ### rtl/pmsp_top.sv
// phy management register port and mac sideband status logic
`timescale 1ns/100ps
`default_nettype none
// Function
// - a mac fault sets bit 13 of the remote fault register at 0xC2.
// - the violation output follows the receive path's detector.
// - each slip request drops one bit or pauses one serial cycle.
// - in 1g timestamp mode the 22-bit latencies are driven.
// - in 10g timestamp mode the 16-bit latencies are driven.
// - transmit permission is raised only once the mac may send.
// - a high management reset holds the register port in reset.
// - stall follows the management reset one cycle late, so it stays high one cycle after requests are served again.
// - registers are word addressed in one address space.
// - every register resets to zero.
module pmsp_top
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic mgmt_reset,
	input wire logic [7:0] mgmt_addr,
	input wire logic [31:0] mgmt_wdata,
	input wire logic mgmt_wr,
	input wire logic mgmt_rd,
	output logic [31:0] mgmt_rdata,
	output logic mgmt_stall,
	output logic irq,
	input wire logic mac_fault_in,
	input wire logic [3:0] test_trigger_in,
	output logic [3:0] test_trigger_out,
	input wire logic rlv_detect,
	output logic run_len_viol,
	input wire logic link_ready,
	output logic tx_permit,
	input wire logic slip_req,
	output logic deser_drop_bit,
	output logic deser_pause_clk,
	input wire logic [21:0] rx_lat_meas,
	input wire logic [21:0] tx_lat_meas,
	output logic [21:0] rx_delay_gig,
	output logic [21:0] tx_delay_gig,
	output logic [15:0] rx_delay_tengig,
	output logic [15:0] tx_delay_tengig
);
	logic [31:0] an_rf_r;
	logic [7:0] ctrl_r;
	logic [3:0] sts_r;
	logic [3:0] sts_nxt;
	logic [3:0] mask_r;
	logic [3:0] ev;
	logic [31:0] rdata_r;
	logic stall_r;
	logic irq_r;
	logic rlv_r;
	logic permit_r;
	logic fault_q;
	logic [3:0] trig_r;
	logic wr_ok;
	logic rd_ok;
	logic [21:0] lat_in [2];
	logic [21:0] gig_r [2];
	logic [15:0] ten_r [2];
	logic ts_gig;
	logic ts_ten;
	pmsp_slip_if sl ();

	// -----------------------------------------------------------------
	// management access decode
	// -----------------------------------------------------------------
	// requests are refused while the management reset is high
	assign wr_ok = mgmt_wr && !mgmt_reset;
	assign rd_ok = mgmt_rd && !mgmt_reset;

	// stall mirrors the management reset, one cycle behind
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			stall_r <= 1'b0;
		else
			stall_r <= mgmt_reset;
	end

	// -----------------------------------------------------------------
	// writable registers
	// -----------------------------------------------------------------
	// control word, cleared by either reset
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ctrl_r <= pmsp_pkg::RST_VAL[7:0];
		else if (mgmt_reset)
			ctrl_r <= pmsp_pkg::RST_VAL[7:0];
		else if (wr_ok && mgmt_addr == pmsp_pkg::OFS_CTRL)
			ctrl_r <= mgmt_wdata[7:0];
	end

	// remote fault record; a fault wins over a clearing write
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			an_rf_r <= pmsp_pkg::RST_VAL;
		else if (mgmt_reset)
			an_rf_r <= pmsp_pkg::RST_VAL;
		else
		begin
			if (wr_ok && mgmt_addr == pmsp_pkg::OFS_AN_RF)
				an_rf_r <= mgmt_wdata;
			if (mac_fault_in)
				an_rf_r[pmsp_pkg::RF_BIT] <= 1'b1;
		end
	end

	// interrupt mask
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			mask_r <= pmsp_pkg::RST_VAL[3:0];
		else if (mgmt_reset)
			mask_r <= pmsp_pkg::RST_VAL[3:0];
		else if (wr_ok && mgmt_addr == pmsp_pkg::OFS_MASK)
			mask_r <= mgmt_wdata[3:0];
	end

	// -----------------------------------------------------------------
	// events and interrupt
	// -----------------------------------------------------------------
	// fault edge, violation, slip done, permission gained
	assign ev[pmsp_pkg::IRQ_FAULT] = mac_fault_in && !fault_q;
	assign ev[pmsp_pkg::IRQ_RLV] = rlv_detect && !rlv_r;
	assign ev[pmsp_pkg::IRQ_SLIP] = sl.done;
	assign ev[pmsp_pkg::IRQ_PERMIT] = tx_permit_nxt() && !permit_r;

	// write one to clear; a new event wins over the clear
	always_comb
	begin
		sts_nxt = sts_r;
		if (wr_ok && mgmt_addr == pmsp_pkg::OFS_IRQ)
			sts_nxt = sts_r & ~mgmt_wdata[3:0];
		sts_nxt = sts_nxt | ev;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sts_r <= pmsp_pkg::RST_VAL[3:0];
			irq_r <= 1'b0;
			fault_q <= 1'b0;
		end
		else
		begin
			sts_r <= mgmt_reset ? pmsp_pkg::RST_VAL[3:0] : sts_nxt;
			irq_r <= !mgmt_reset && |(sts_nxt & mask_r);
			fault_q <= mac_fault_in;
		end
	end

	// -----------------------------------------------------------------
	// mac sideband
	// -----------------------------------------------------------------
	function automatic logic tx_permit_nxt();
		return ctrl_r[pmsp_pkg::CTL_PERMIT] && link_ready;
	endfunction : tx_permit_nxt

	// violation, permission and trigger outputs
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rlv_r <= 1'b0;
			permit_r <= 1'b0;
			trig_r <= 4'h0;
		end
		else
		begin
			rlv_r <= rlv_detect;
			permit_r <= tx_permit_nxt();
			trig_r <= test_trigger_in |
				ctrl_r[pmsp_pkg::CTL_TRIG_LSB +: pmsp_pkg::TRIG_W];
		end
	end

	// slip sequencer, drop or pause chosen by control
	assign sl.req = slip_req;
	assign sl.pause_mode = ctrl_r[pmsp_pkg::CTL_PAUSE];

	pmsp_slip u_slip
	(
		.clk (clk),
		.rst_b (rst_b),
		.sl (sl)
	);

	// -----------------------------------------------------------------
	// timestamp latency outputs, rx then tx
	// -----------------------------------------------------------------
	assign ts_gig = ctrl_r[pmsp_pkg::CTL_TS_EN] && !ctrl_r[pmsp_pkg::CTL_10G];
	assign ts_ten = ctrl_r[pmsp_pkg::CTL_TS_EN] && ctrl_r[pmsp_pkg::CTL_10G];
	assign lat_in[0] = rx_lat_meas;
	assign lat_in[1] = tx_lat_meas;

	for (genvar g = 0; g < 2; g++)
	begin : g_lat
		// 10g word saturates when whole cycles exceed six bits
		always_ff @(posedge clk or negedge rst_b)
		begin
			if (!rst_b)
			begin
				gig_r[g] <= 22'h0;
				ten_r[g] <= 16'h0;
			end
			else
			begin
				gig_r[g] <= ts_gig ? lat_in[g] : 22'h0;
				if (!ts_ten)
					ten_r[g] <= 16'h0;
				else if (|lat_in[g][21:16])
					ten_r[g] <= pmsp_pkg::LAT_TEN_MAX;
				else
					ten_r[g] <= lat_in[g][15:0];
			end
		end
	end

	// -----------------------------------------------------------------
	// read data, valid the cycle after the strobe
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata_r <= pmsp_pkg::RST_VAL;
		else if (!rd_ok)
			rdata_r <= 32'h0;
		else
			unique case (mgmt_addr)
				pmsp_pkg::OFS_AN_RF: rdata_r <= an_rf_r;
				pmsp_pkg::OFS_CTRL: rdata_r <= {24'h0, ctrl_r};
				pmsp_pkg::OFS_STAT: rdata_r <= {27'h0, stall_r,
					mac_fault_in, permit_r, rlv_r, sl.done};
				pmsp_pkg::OFS_IRQ: rdata_r <= {28'h0, sts_r};
				pmsp_pkg::OFS_MASK: rdata_r <= {28'h0, mask_r};
				pmsp_pkg::OFS_RXLAT: rdata_r <= {10'h0, gig_r[0]};
				pmsp_pkg::OFS_TXLAT: rdata_r <= {10'h0, gig_r[1]};
				default: rdata_r <= 32'h0;
			endcase
	end

	// -----------------------------------------------------------------
	// output ports
	// -----------------------------------------------------------------
	assign mgmt_rdata = rdata_r;
	assign mgmt_stall = stall_r;
	assign irq = irq_r;
	assign test_trigger_out = trig_r;
	assign run_len_viol = rlv_r;
	assign tx_permit = permit_r;
	assign deser_drop_bit = sl.drop_bit;
	assign deser_pause_clk = sl.pause_clk;
	assign rx_delay_gig = gig_r[0];
	assign tx_delay_gig = gig_r[1];
	assign rx_delay_tengig = ten_r[0];
	assign tx_delay_tengig = ten_r[1];

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	property p_fault_rec;
		mac_fault_in && !mgmt_reset |=> an_rf_r[pmsp_pkg::RF_BIT];
	endproperty
	a_fault_rec: assert property (p_fault_rec)
		else $error("fault not recorded in remote fault bit");

	property p_rlv;
		rlv_detect |=> run_len_viol ##1 (run_len_viol == $past(rlv_detect));
	endproperty
	a_rlv: assert property (p_rlv)
		else $error("violation output does not follow detector");

	property p_gig;
		ts_gig |=> rx_delay_gig == $past(rx_lat_meas) &&
			tx_delay_gig == $past(tx_lat_meas);
	endproperty
	a_gig: assert property (p_gig)
		else $error("1g latency not driven");

	property p_ten;
		ts_ten && !(|rx_lat_meas[21:16]) |=>
			rx_delay_tengig == $past(rx_lat_meas[15:0]) && rx_delay_gig == 22'h0;
	endproperty
	a_ten: assert property (p_ten)
		else $error("10g latency not driven");

	property p_permit;
		tx_permit |-> $past(ctrl_r[pmsp_pkg::CTL_PERMIT]) && $past(link_ready);
	endproperty
	a_permit: assert property (p_permit)
		else $error("transmit permission without link ready");

	property p_mrst;
		mgmt_reset [*2] |-> ctrl_r == 8'h0 && mask_r == 4'h0 && !irq;
	endproperty
	a_mrst: assert property (p_mrst)
		else $error("management reset did not clear registers");

	property p_stall;
		mgmt_reset |=> mgmt_stall ##1 (mgmt_stall == $past(mgmt_reset));
	endproperty
	a_stall: assert property (p_stall)
		else $error("stall does not track management reset");

	property p_ctrl_rd;
		mgmt_wr && !mgmt_reset && mgmt_addr == pmsp_pkg::OFS_CTRL ##1
			mgmt_rd && !mgmt_reset && mgmt_addr == pmsp_pkg::OFS_CTRL |=>
			mgmt_rdata[7:0] == $past(mgmt_wdata[7:0], 2);
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd)
		else $error("control readback differs from write");

	// read data stands only in the cycle after an accepted read
	property p_rd_idle;
		!$past(rd_ok) |-> mgmt_rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside the cycle after a read");

	// the slave stalls only during the management reset and the cycle after it
	property p_no_stall;
		!mgmt_reset && !$past(mgmt_reset) |-> !mgmt_stall;
	endproperty
	a_no_stall: assert property (p_no_stall)
		else $error("stall raised outside management reset");

	c_fault: cover property (mac_fault_in ##1 irq);
	c_permit: cover property ($rose(tx_permit));
	c_ten: cover property (ts_ten ##1 rx_delay_tengig != 16'h0);
endmodule : pmsp_top
`default_nettype wire

// ### verification/pmsp_mac_model.sv
// mac and receive-path model that drives the sideband inputs
`timescale 1ns/100ps
`default_nettype none
module pmsp_mac_model
(
	input wire logic clk,
	input wire logic tx_permit,
	output logic mac_fault_in,
	output logic [3:0] test_trigger_in,
	output logic rlv_detect,
	output logic link_ready,
	output logic slip_req,
	output logic [21:0] rx_lat_meas,
	output logic [21:0] tx_lat_meas
);
	int frames_sent = 0;
	// ------------------------------------------------------------
	// idle levels
	// ------------------------------------------------------------
	initial
	begin
		mac_fault_in = 1'b0;
		test_trigger_in = 4'h0; // unused trigger held at zero
		rlv_detect = 1'b0;
		link_ready = 1'b0;
		slip_req = 1'b0;
		rx_lat_meas = 22'h0;
		tx_lat_meas = 22'h0;
	end
	// mac transmits only while permitted
	always @(posedge clk)
		if (tx_permit === 1'b1)
			frames_sent <= frames_sent + 1;
	// one-cycle event: 0 fault, 1 run violation, 2 slip request
	task automatic pulse(input int sel);
		@(posedge clk);
		case (sel)
			0: mac_fault_in <= 1'b1; // remote fault report
			1: rlv_detect <= 1'b1;
			default: slip_req <= 1'b1; // dropped before the next one
		endcase
		@(posedge clk);
		mac_fault_in <= 1'b0;
		rlv_detect <= 1'b0;
		slip_req <= 1'b0;
	endtask : pulse
	// link readiness level
	task automatic set_ready(input logic v);
		@(posedge clk);
		link_ready <= v;
	endtask : set_ready
	// measured path latencies
	task automatic set_lat(input logic [21:0] r, input logic [21:0] t);
		@(posedge clk);
		rx_lat_meas <= r;
		tx_lat_meas <= t;
	endtask : set_lat
endmodule : pmsp_mac_model
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the phy management and status port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk, rst_b, mgmt_reset, mgmt_wr, mgmt_rd, mgmt_stall, irq;
	logic [7:0] mgmt_addr;
	logic [31:0] mgmt_wdata, mgmt_rdata;
	logic mac_fault_in, rlv_detect, run_len_viol, link_ready, tx_permit;
	logic slip_req, deser_drop_bit, deser_pause_clk;
	logic [3:0] test_trigger_in, test_trigger_out;
	logic [21:0] rx_lat_meas, tx_lat_meas, rx_delay_gig, tx_delay_gig;
	logic [15:0] rx_delay_tengig, tx_delay_tengig;
	int n_tests = 0;
	int n_mismatch = 0;
	logic [7:0] regs [8] = '{pmsp_pkg::OFS_AN_RF, pmsp_pkg::OFS_CTRL,
		pmsp_pkg::OFS_STAT, pmsp_pkg::OFS_IRQ, pmsp_pkg::OFS_MASK,
		pmsp_pkg::OFS_RXLAT, pmsp_pkg::OFS_TXLAT, 8'h10};
	// ------------------------------------------------------------
	// design, far side and clock
	// ------------------------------------------------------------
	pmsp_top pmsp_top_i (.clk, .rst_b, .mgmt_reset, .mgmt_addr,
		.mgmt_wdata, .mgmt_wr, .mgmt_rd, .mgmt_rdata, .mgmt_stall, .irq,
		.mac_fault_in, .test_trigger_in, .test_trigger_out, .rlv_detect,
		.run_len_viol, .link_ready, .tx_permit, .slip_req,
		.deser_drop_bit, .deser_pause_clk, .rx_lat_meas, .tx_lat_meas,
		.rx_delay_gig, .tx_delay_gig, .rx_delay_tengig, .tx_delay_tengig);
	pmsp_mac_model pmsp_mac_model_i (.clk, .tx_permit, .mac_fault_in,
		.test_trigger_in, .rlv_detect, .link_ready, .slip_req,
		.rx_lat_meas, .tx_lat_meas);
	always #2.5 clk = ~clk; // single clock, shared by the design and the mac model
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		mgmt_addr <= a;
		mgmt_wdata <= d;
		mgmt_wr <= 1'b1;
		@(posedge clk);
		mgmt_wr <= 1'b0;
	endtask : wr
	// read, then compare the word in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		mgmt_addr <= a;
		mgmt_rd <= 1'b1;
		@(posedge clk);
		mgmt_rd <= 1'b0;
		#1;
		check(mgmt_rdata, exp);
	endtask : rd_chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic done(input string s);
		$display("test %s done, mismatches so far %0d", s, n_mismatch);
	endtask : done
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	// watchdog well beyond the expected run
	initial
	begin
		#(5000 * 5);
		n_mismatch++;
		conclude();
	end
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		mgmt_reset = 1'b0;
		mgmt_addr = 8'h00;
		mgmt_wdata = 32'h0;
		mgmt_wr = 1'b0;
		mgmt_rd = 1'b0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		foreach (regs[i]) rd_chk(regs[i], 32'h0);
		done("reset values");
		wr(pmsp_pkg::OFS_AN_RF, 32'hA5A5_1234);
		wr(pmsp_pkg::OFS_MASK, 32'h0000_0001);
		wr(8'h10, 32'hFFFF_FFFF);
		wr(pmsp_pkg::OFS_CTRL, 32'h0000_00A0);
		rd_chk(pmsp_pkg::OFS_AN_RF, 32'hA5A5_1234);
		rd_chk(pmsp_pkg::OFS_MASK, 32'h0000_0001);
		rd_chk(8'h10, 32'h0);
		check(32'(test_trigger_out), 32'hA);
		done("register access");
		pmsp_mac_model_i.pulse(0);
		#1;
		check(32'(irq), 32'h1);
		rd_chk(pmsp_pkg::OFS_AN_RF, 32'hA5A5_3234);
		rd_chk(pmsp_pkg::OFS_IRQ, 32'h1);
		wr(pmsp_pkg::OFS_IRQ, 32'h1);
		tick(2);
		check(32'(irq), 32'h0);
		done("remote fault");
		pmsp_mac_model_i.pulse(1);
		#1;
		check(32'(run_len_viol), 32'h1);
		check(32'(irq), 32'h0);
		tick(1);
		check(32'(run_len_viol), 32'h0);
		done("run length");
		for (int m = 0; m < 2; m++)
		begin
			wr(pmsp_pkg::OFS_CTRL, 32'(m) << pmsp_pkg::CTL_PAUSE);
			pmsp_mac_model_i.pulse(2);
			#1;
			check(32'({deser_drop_bit, deser_pause_clk}), 2 - m);
			tick(1);
			check(32'({deser_drop_bit, deser_pause_clk}), 32'h0);
		end
		rd_chk(pmsp_pkg::OFS_IRQ, 32'h6);
		done("bit slip");
		wr(pmsp_pkg::OFS_CTRL, 32'h4);
		pmsp_mac_model_i.set_ready(1'b0);
		tick(2);
		check(32'(tx_permit), 32'h0);
		check(pmsp_mac_model_i.frames_sent, 32'h0);
		pmsp_mac_model_i.set_ready(1'b1);
		tick(2);
		check(32'(tx_permit), 32'h1);
		check(32'(pmsp_mac_model_i.frames_sent != 0), 32'h1);
		done("transmit permission");
		pmsp_mac_model_i.set_lat(22'h2A_BCDE, 22'h01_2345);
		wr(pmsp_pkg::OFS_CTRL, 32'h1);
		tick(2);
		check(32'(rx_delay_gig), 32'h2A_BCDE);
		check(32'(tx_delay_gig), 32'h01_2345);
		check(32'(rx_delay_tengig), 32'h0);
		pmsp_mac_model_i.set_lat(22'h00_ABCD, 22'h01_2345);
		// write then read of control with no gap between strobes
		@(posedge clk);
		mgmt_addr <= pmsp_pkg::OFS_CTRL;
		mgmt_wdata <= 32'h1;
		mgmt_wr <= 1'b1;
		@(posedge clk);
		mgmt_wr <= 1'b0;
		mgmt_rd <= 1'b1;
		@(posedge clk);
		mgmt_rd <= 1'b0;
		#1;
		check(mgmt_rdata, 32'h1);
		wr(pmsp_pkg::OFS_CTRL, mgmt_rdata | 32'h6);
		tick(2);
		check(32'(rx_delay_tengig), 32'hABCD);
		check(32'(tx_delay_tengig), 32'hFFFF);
		check(32'(rx_delay_gig), 32'h0);
		done("latency");
		@(posedge clk);
		mgmt_reset <= 1'b1;
		@(posedge clk);
		mgmt_addr <= pmsp_pkg::OFS_MASK; // write raised under reset
		mgmt_wdata <= 32'hF;
		mgmt_wr <= 1'b1;
		tick(1);
		check(32'(mgmt_stall), 32'h1);
		@(posedge clk);
		mgmt_reset <= 1'b0;
		// the write stands unchanged until stall is seen low
		do @(posedge clk); while (mgmt_stall !== 1'b0);
		mgmt_wr <= 1'b0;
		tick(1);
		check(32'(mgmt_stall), 32'h0);
		check(32'(tx_permit), 32'h0);
		rd_chk(pmsp_pkg::OFS_AN_RF, 32'h0);
		rd_chk(pmsp_pkg::OFS_MASK, 32'hF);
		done("management reset");
		conclude();
	end
endmodule : tb_top
`default_nettype wire
